//--- qfp_serial_port.sv
// Serial frame port of a four-input 10-bit converter, device end.
// Assumes the host drives serial clock, frame select and data in asynchronously;
// conversion results arrive on a valid/ready stream from the converter core.
//
// How it works
// - Each conversion spans 16 serial clock cycles: 3 of tracking, then 13 of conversion.
// - With frame select low the port is operational; with it high all activity stops except the result buffer filling.
// - Once frame select falls the data output is driven instead of left floating.
// - The data output changes only after each falling serial clock edge.
// - The host sets data in up before a rising edge and the port samples it on that edge.
// - When frame select rises the data output is released.
// - The channel address shifted in during a conversion applies to the next one.
// - The input is held at the fourth falling edge, which ends tracking.
`include "qfp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module qfp_serial_port #(
    parameter int RES_BITS   = `QFP_RESULT_BITS,
    parameter int FIFO_DEPTH = `QFP_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    // Serial pins.
    input  wire logic                i_sclk,
    input  wire logic                i_cs_n,
    input  wire logic                i_din,
    output logic                     o_dout,
    output logic                     o_dout_oe,
    // Converter core results.
    input  wire logic                i_res_valid,
    input  wire logic [RES_BITS-1:0] i_res_data,
    output logic                     o_res_ready,
    // Converter core control.
    output logic                     o_active,
    output logic                     o_track,
    output logic                     o_hold,
    output logic [1:0]               o_chan
);
    // ========================================================================
    // Pin synchronisers.
    // ========================================================================
    logic [`QFP_SYNC_STAGES-1:0] sclk_s_q, cs_s_q, din_s_q;
    logic [2:0]                  filt_q, filt_d;
    logic                        sclk_f, cs_f, din_f, sclk_p;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_s_q <= '0;
            cs_s_q   <= '1;
            din_s_q  <= '0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], i_sclk};
            cs_s_q   <= {cs_s_q[1:0], i_cs_n};
            din_s_q  <= {din_s_q[1:0], i_din};
        end
    end

    // A level counts once the second and third stages agree.
    always_comb begin
        filt_d = filt_q;
        if (sclk_s_q[1] == sclk_s_q[2]) begin
            filt_d[0] = sclk_s_q[2];
        end
        if (cs_s_q[1] == cs_s_q[2]) begin
            filt_d[1] = cs_s_q[2];
        end
        if (din_s_q[1] == din_s_q[2]) begin
            filt_d[2] = din_s_q[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            filt_q <= 3'h2;
            sclk_p <= 1'b0;
        end else begin
            filt_q <= filt_d;
            sclk_p <= filt_q[0];
        end
    end

    assign sclk_f = filt_q[0];
    assign cs_f   = filt_q[1];
    assign din_f  = filt_q[2];

    logic sclk_rise, sclk_fall, sel;
    assign sel       = !cs_f;
    assign sclk_rise = sel && sclk_f && !sclk_p;
    assign sclk_fall = sel && !sclk_f && sclk_p;

    // ========================================================================
    // Result buffer.
    // ========================================================================
    qfp_stream_if #(.WIDTH(RES_BITS)) fill_if ();
    qfp_stream_if #(.WIDTH(RES_BITS)) drain_if ();

    assign fill_if.valid = i_res_valid;
    assign fill_if.data  = i_res_data;

    qfp_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .wr      (fill_if.sink),
        .rd      (drain_if.source)
    );

    // ========================================================================
    // Frame sequencer and shifters.
    // ========================================================================
    qfp_pkg::qfp_phase_type phase_q, phase_d;
    logic [3:0]          cnt_q, cnt_d;
    logic [RES_BITS+1:0] sh_q, sh_d;
    logic [7:0]          ctl_q, ctl_d;
    logic [1:0]          next_chan_q, next_chan_d, chan_q, chan_d;
    logic                dout_q, dout_d, oe_q, oe_d, hold_q, hold_d;
    logic                rdy_q, rdy_d, pop;
    logic [3:0]          rcnt_q, rcnt_d;
    logic                active_q, active_d, track_q, track_d;
    logic [RES_BITS-1:0] res;

    // An empty buffer yields a zero code rather than stalling the frame.
    assign res            = drain_if.valid ? drain_if.data : '0;
    assign pop            = sclk_fall && (cnt_q == `QFP_HOLD_INDEX);
    assign drain_if.ready = pop;

    always_comb begin
        phase_d     = phase_q;
        cnt_d       = cnt_q;
        sh_d        = sh_q;
        ctl_d       = ctl_q;
        next_chan_d = next_chan_q;
        chan_d      = chan_q;
        dout_d      = dout_q;
        rcnt_d      = rcnt_q;
        hold_d      = 1'b0;
        oe_d        = sel;
        rdy_d       = fill_if.ready;
        if (!sel) begin
            phase_d = qfp_pkg::QFP_SHUTDOWN;
            cnt_d   = '0;
            rcnt_d  = '0;
            dout_d  = 1'b0;
            sh_d    = '0;
        end else begin
            if (phase_q == qfp_pkg::QFP_SHUTDOWN) begin
                phase_d = qfp_pkg::QFP_TRACK;
            end
            // Rising edges keep their own count: with the clock idling high they
            // follow the falling edge of the same cycle instead of leading it.
            if (sclk_rise) begin
                rcnt_d = rcnt_q + 4'h1;
                if (rcnt_q < `QFP_CTL_BITS) begin
                    ctl_d = {ctl_q[6:0], din_f};
                end
                if (rcnt_q == `QFP_CTL_BITS - 4'h1) begin
                    next_chan_d = {ctl_q[`QFP_CHAN_MSB-1], ctl_q[`QFP_CHAN_LSB-1]};
                end
            end
            if (sclk_fall) begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == `QFP_HOLD_INDEX) begin
                    phase_d = qfp_pkg::QFP_CONVERT;
                    hold_d  = 1'b1;
                    chan_d  = next_chan_q;
                    dout_d  = res[RES_BITS-1];
                    sh_d    = {res[RES_BITS-2:0], 3'h0};
                end else begin
                    dout_d  = sh_q[RES_BITS+1];
                    sh_d    = {sh_q[RES_BITS:0], 1'b0};
                end
                if (cnt_q == `QFP_LAST_INDEX) begin
                    phase_d = qfp_pkg::QFP_TRACK;
                end
            end
        end
        active_d = (phase_d != qfp_pkg::QFP_SHUTDOWN);
        track_d  = (phase_d == qfp_pkg::QFP_TRACK);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_q     <= qfp_pkg::QFP_SHUTDOWN;
            cnt_q       <= '0;
            sh_q        <= '0;
            ctl_q       <= '0;
            next_chan_q <= `QFP_CHAN_RESET;
            chan_q      <= `QFP_CHAN_RESET;
            dout_q      <= 1'b0;
            oe_q        <= 1'b0;
            hold_q      <= 1'b0;
            rdy_q       <= 1'b0;
            rcnt_q      <= '0;
            active_q    <= 1'b0;
            track_q     <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            cnt_q       <= cnt_d;
            sh_q        <= sh_d;
            ctl_q       <= ctl_d;
            next_chan_q <= next_chan_d;
            chan_q      <= chan_d;
            dout_q      <= dout_d;
            oe_q        <= oe_d;
            hold_q      <= hold_d;
            rdy_q       <= rdy_d;
            rcnt_q      <= rcnt_d;
            active_q    <= active_d;
            track_q     <= track_d;
        end
    end

    assign o_dout      = dout_q;
    assign o_dout_oe   = oe_q;
    assign o_hold      = hold_q;
    assign o_chan      = chan_q;
    assign o_res_ready = rdy_q;
    assign o_active    = active_q;
    assign o_track     = track_q;

endmodule : qfp_serial_port

`default_nettype wire

//--- qfp_params.svh
// Constants of the serial frame port: frame timing, result layout, channel field.
// Assumes inclusion by bare name from every file that needs them.
`ifndef QFP_PARAMS_SVH
`define QFP_PARAMS_SVH

`define QFP_TRACK_CYCLES   4'h3
`define QFP_CONV_CYCLES    4'hd
`define QFP_FRAME_CYCLES   5'h10
`define QFP_HOLD_INDEX     4'h3
`define QFP_LAST_INDEX     4'hf
`define QFP_RESULT_BITS    10
`define QFP_CTL_BITS       4'h8
`define QFP_CHAN_MSB       4
`define QFP_CHAN_LSB       3
`define QFP_CHAN_RESET     2'h0
`define QFP_SYNC_STAGES    3
`define QFP_FIFO_DEPTH     32

`endif

//--- qfp_pkg.sv
// Types shared by the serial frame port modules.
// Assumes nothing of its surroundings.
package qfp_pkg;

    // Gray codes along shutdown, track, convert.
    typedef enum logic [1:0] {
        QFP_SHUTDOWN = 2'h0,
        QFP_TRACK    = 2'h1,
        QFP_CONVERT  = 2'h3
    } qfp_phase_type;

endpackage : qfp_pkg

//--- qfp_stream_if.sv
// Valid/ready stream between the frame port and its result buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface qfp_stream_if #(
    parameter int WIDTH = 10
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : qfp_stream_if

`default_nettype wire

//--- qfp_fifo.sv
// Result buffer: synchronous FIFO with registered full and empty flags.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module qfp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    // Filling side.
    qfp_stream_if.sink  wr,
    // Draining side.
    qfp_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             full_q, full_d, empty_q, empty_d;
    logic             push, pop;

    assign push     = wr.valid && !full_q;
    assign pop      = rd.ready && !empty_q;
    assign wr.ready = !full_q;
    assign rd.valid = !empty_q;
    assign rd.data  = mem[rp_q];

    always_comb begin
        wp_d    = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d    = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d   = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        full_d  = (cnt_d == (AW+1)'(DEPTH));
        empty_d = (cnt_d == '0);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            full_q  <= full_d;
            empty_q <= empty_d;
        end
    end

    // Storage carries no reset.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end

endmodule : qfp_fifo

`default_nettype wire

//--- qfp_serial_port_end.sv
// Holds no logic of its own; the serial frame port lives in qfp_serial_port.sv.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- qfp_serial_port_properties.sv
// Checker of the serial frame port pins and converter control outputs.
// Assumes binding to qfp_serial_port on its own clock and reset.
`timescale 1ns/1ps
`default_nettype none
module qfp_serial_port_properties (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_sclk,
    input wire logic       i_cs_n,
    input wire logic       o_dout,
    input wire logic       o_dout_oe,
    input wire logic       o_active,
    input wire logic       o_track,
    input wire logic       o_hold,
    input wire logic [1:0] o_chan
);
    // ====
    // Properties.
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_open; $fell(i_cs_n) ##1 !i_cs_n [*7]; endsequence
    sequence s_idle; i_cs_n [*7]; endsequence
    property p_drive; s_open |-> o_dout_oe; endproperty
    property p_release; s_idle |-> !o_dout_oe; endproperty
    property p_shut; s_idle |-> !o_active && !o_hold && !o_track; endproperty
    property p_shift; $fell(i_sclk) && !i_cs_n |-> $stable(o_dout) [*4]; endproperty
    property p_hold; o_hold |=> (!o_hold && !o_track) [*8]; endproperty
    property p_hold_on; o_hold |-> o_active && o_dout_oe; endproperty
    property p_chan; $changed(o_chan) |-> o_hold || $past(o_hold); endproperty
    property p_track; $rose(o_active) |-> o_track; endproperty
    a_drive: assert property (p_drive) else $error("output idle in frame");
    a_release: assert property (p_release) else $error("output kept driven");
    a_shut: assert property (p_shut) else $error("activity while idle");
    a_shift: assert property (p_shift) else $error("data moved early");
    a_hold: assert property (p_hold) else $error("hold pulse bad");
    a_hold_on: assert property (p_hold_on) else $error("hold outside frame");
    a_chan: assert property (p_chan) else $error("channel moved alone");
    a_track: assert property (p_track) else $error("frame not tracking");
endmodule : qfp_serial_port_properties
`default_nettype wire

//--- qfp_host_model.sv
// Host controller model: frame select, serial clock, data in, result capture.
// Assumes the bench queues one channel per group in chans before a frame.
`timescale 1ns/1ps
`default_nettype none
module qfp_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    input  wire logic i_dout,
    input  wire logic i_dout_oe
);
    // ====
    // Frame driver.
    logic [1:0]  chans[$];
    logic [15:0] words[$];
    logic        last = 1'b0;
    logic        pin;
    // A released line shows the inverse of its last level.
    assign pin = i_dout_oe ? i_dout : ~last;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    task automatic frame(input int groups, input logic idle);
        logic [7:0]  ctl;
        logic [15:0] w;
        int          r;
        #17 o_sclk = idle;
        #400 o_cs_n = 1'b0;
        for (int g = 0; g < groups; g++) begin
            ctl = 8'($urandom);
            ctl[4:3] = chans.pop_front();
            o_din = ctl[7];
            r = 0;
            #400;
            for (int e = 0; e < 32; e++) begin
                if (o_sclk) begin
                    w = {w[14:0], pin};
                    last = pin;
                    o_din = (r < 8) ? ctl[3'(7 - r)] : 1'($urandom);
                end else begin
                    r++;
                end
                o_sclk = ~o_sclk;
                #200;
            end
            words.push_back(w);
        end
        #400 o_cs_n = 1'b1;
        #800;
    endtask : frame
endmodule : qfp_host_model
`default_nettype wire

//--- quad_adc_serial_frame_port_bench.sv
// Self-checking bench of the serial frame port with a host model.
// Assumes the design, buffer, interface and checker files compile first.
`timescale 1ns/1ps
`default_nettype none
module quad_adc_serial_frame_port_bench;
    // ====
    // Signals and expectations.
    logic       i_clk, i_rst_n, i_res_valid, o_dout, o_dout_oe, o_res_ready;
    logic       o_active, o_track, o_hold, sclk, cs_n, din;
    logic [9:0] i_res_data;
    logic [1:0] o_chan;
    int         err_count, samples_checked, holds, total;
    int         res_q[$], chan_q[$];
    qfp_serial_port #(.FIFO_DEPTH(4)) dut (.i_clk, .i_rst_n, .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .o_dout, .o_dout_oe, .i_res_valid, .i_res_data, .o_res_ready,
        .o_active, .o_track, .o_hold, .o_chan);
    qfp_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(o_dout),
        .i_dout_oe(o_dout_oe));
    always #25 i_clk = ~i_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    // ====
    // Result buffer filling; refused words are not expected back.
    task automatic fill(input int n);
        logic acc;
        @(posedge i_clk);
        repeat (n) begin
            i_res_data <= 10'($urandom);
            i_res_valid <= 1'b1;
            @(negedge i_clk);
            acc = o_res_ready === 1'b1 && res_q.size() < 4;
            @(posedge i_clk);
            if (acc) res_q.push_back(int'(i_res_data));
        end
        i_res_valid <= 1'b0;
        @(negedge i_clk);
    endtask : fill
    task automatic run(input int n, input logic idle);
        logic [1:0] c;
        int         r;
        for (int g = 0; g < n; g++) begin
            c = 2'($urandom);
            host.chans.push_back(c);
            chan_q.push_back(int'(c));
        end
        total += n;
        host.frame(n, idle);
        for (int g = 0; g < n; g++) begin
            r = res_q.size() > 0 ? res_q.pop_front() : 0;
            check(host.words.pop_front(), 16'(r << 2));
        end
    endtask : run
    // Channel seen at each hold is the one sent during the group before.
    always @(negedge i_clk) begin
        if (o_hold === 1'b1) begin
            check(16'(o_chan), 16'(chan_q.pop_front()));
            holds++;
        end
    end
    // ====
    // Main sequence and watchdog.
    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_res_valid = 1'b0;
        i_res_data = 10'h000;
        void'($urandom(32'h13c8));
        chan_q.push_back(0);
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        fill(6);
        check(16'(o_res_ready), 16'h0000);
        for (int f = 0; f < 5; f++) begin
            if (f == 3) fill(2);
            run(f == 0 ? 3 : 1 + $urandom_range(1), 1'(f));
        end
        check(16'(holds), 16'(total));
        print_verdict();
    end
    initial begin
        #400us;
        err_count++;
        print_verdict();
    end
endmodule : quad_adc_serial_frame_port_bench
bind qfp_serial_port qfp_serial_port_properties u_props (.i_clk, .i_rst_n, .i_sclk,
    .i_cs_n, .o_dout, .o_dout_oe, .o_active, .o_track, .o_hold, .o_chan);
`default_nettype wire
